// File: tac_config_regs.v
// touch timing and audio path configuration registers behind a serial port
`timescale 1ns/100ps
`include "tac_regs.vh"
module tac_config_regs
#(
    parameter TICK_CYCLES = `TAC_TICK_CYCLES
)
(
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire sclk,
    input wire ss_n,
    input wire mosi,
    output reg miso,
    output reg miso_oe,
    input wire touch_seq_start,
    output reg precharge_active,
    output reg sense_active,
    output reg touch_seq_done,
    input wire base_fs_tick,
    output reg playback_fs_tick,
    output reg record_fs_tick,
    output reg record_hpf_enable,
    output reg [1:0] record_hpf_corner,
    output reg record_in_mic,
    output reg record_in_aux,
    output reg record_in_diff,
    output reg [5:0] serial_word_length,
    output reg [3:0] serial_frame_format
);
    localparam ST_IDLE = 3'b001;
    localparam ST_PRE = 3'b010;
    localparam ST_SENSE = 3'b100;
    localparam [15:0] TOUCH_DEF = `TAC_TOUCH_TIMING_DEF;
    localparam [15:0] AUDIO_DEF = `TAC_AUDIO_PATH_DEF;

    // registers as stored; reserved positions are not stored at all
    reg [15:0] reset_all_word;
    reg [5:0] touch_timing;
    reg [7:0] audio_hi;
    reg [5:0] audio_lo;
    reg soft_clr;

    // serial port state
    reg sclk_q;
    reg [5:0] bit_cnt;
    reg [15:0] rx_shift;
    reg [15:0] cmd;
    reg cmd_done;
    reg [15:0] tx_shift;

    // touch sequencer
    reg [2:0] seq_state;
    reg [2:0] next_seq_state;
    reg tmr_load;
    reg [11:0] tmr_us;
    wire tmr_done;
    wire play_tick;
    wire rec_tick;

    wire sclk_rise;
    wire sclk_fall;
    wire [15:0] rx_word;
    wire [3:0] cmd_page;
    wire [5:0] cmd_addr;
    wire word_end;
    wire wr_strobe;
    wire [15:0] touch_rd;
    wire [15:0] audio_rd;
    wire [2:0] pre_sel;
    wire [2:0] sense_sel;
    reg [15:0] rd_data;

    assign sclk_rise = sclk & ~sclk_q;
    assign sclk_fall = ~sclk & sclk_q;
    assign rx_word = {rx_shift[14:0], mosi};
    assign cmd_page = cmd[`TAC_CMD_PAGE_MSB:`TAC_CMD_PAGE_LSB];
    assign cmd_addr = cmd[`TAC_CMD_ADDR_MSB:`TAC_CMD_ADDR_LSB];
    assign word_end = ~ss_n & sclk_rise
        & (bit_cnt[3:0] == 4'hf) & (bit_cnt[5:4] != 2'b10);
    assign wr_strobe = word_end & cmd_done & ~cmd[`TAC_CMD_READ_BIT];
    assign pre_sel = touch_timing[`TAC_PRE_MSB:`TAC_PRE_LSB];
    assign sense_sel = touch_timing[`TAC_SENSE_MSB:`TAC_SENSE_LSB];

    // reserved bits are padded back in as zero on read
    assign touch_rd = {10'h000, touch_timing};
    assign audio_rd = {audio_hi, 2'b00, audio_lo};

    always @*
    begin
        rd_data = 16'h0000;
        if (cmd_page == `TAC_PAGE_TOUCH)
        begin
            if (cmd_addr == `TAC_ADDR_SOFT_RESET)
                rd_data = reset_all_word;
            else if (cmd_addr == `TAC_ADDR_TOUCH_TIMING)
                rd_data = touch_rd;
        end
        else if (cmd_page == `TAC_PAGE_AUDIO)
        begin
            if (cmd_addr == `TAC_ADDR_AUDIO_PATH)
                rd_data = audio_rd;
        end
    end

    // serial port: mode 0, msb first, command word then data word;
    // sclk is sampled by clk, so it must run below a quarter of clk
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q <= 1'b0;
            bit_cnt <= 6'h00;
            rx_shift <= 16'h0000;
            cmd <= 16'h0000;
            cmd_done <= 1'b0;
            tx_shift <= 16'h0000;
            miso <= 1'b0;
            miso_oe <= 1'b0;
        end
        else if (ce)
        begin
            sclk_q <= sclk;
            if (ss_n)
            begin
                bit_cnt <= 6'h00;
                cmd_done <= 1'b0;
                miso_oe <= 1'b0;
                miso <= 1'b0;
            end
            else
            begin
                if (sclk_rise && bit_cnt != 6'h20)
                begin
                    rx_shift <= rx_word;
                    bit_cnt <= bit_cnt + 6'h01;
                    if (bit_cnt == 6'h0f)
                    begin
                        cmd <= rx_word;
                        cmd_done <= 1'b1;
                    end
                end
                if (cmd_done && cmd[`TAC_CMD_READ_BIT] && bit_cnt == 6'h10
                    && sclk_q)
                begin
                    // load while sclk is still high after the command word;
                    // the shift at the next fall wins, so bit 15 goes first
                    tx_shift <= rd_data;
                end
                if (sclk_fall && cmd_done && cmd[`TAC_CMD_READ_BIT]
                    && bit_cnt != 6'h20)
                begin
                    miso_oe <= 1'b1;
                    miso <= tx_shift[15];
                    tx_shift <= {tx_shift[14:0], 1'b0};
                end
            end
        end
    end

    // register writes; the magic word restores every default at once
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reset_all_word <= `TAC_SOFT_RESET_DEF;
            touch_timing <= TOUCH_DEF[5:0];
            audio_hi <= AUDIO_DEF[15:8];
            audio_lo <= AUDIO_DEF[5:0];
            soft_clr <= 1'b0;
        end
        else if (ce)
        begin
            soft_clr <= 1'b0;
            if (wr_strobe && cmd_page == `TAC_PAGE_TOUCH
                && cmd_addr == `TAC_ADDR_SOFT_RESET)
            begin
                if (rx_word == `TAC_RESET_MAGIC)
                begin
                    reset_all_word <= `TAC_SOFT_RESET_DEF;
                    touch_timing <= TOUCH_DEF[5:0];
                    audio_hi <= AUDIO_DEF[15:8];
                    audio_lo <= AUDIO_DEF[5:0];
                    soft_clr <= 1'b1;
                end
                else
                    reset_all_word <= rx_word;
            end
            else if (wr_strobe && cmd_page == `TAC_PAGE_TOUCH
                && cmd_addr == `TAC_ADDR_TOUCH_TIMING)
                touch_timing <= rx_word[5:0];
            else if (wr_strobe && cmd_page == `TAC_PAGE_AUDIO
                && cmd_addr == `TAC_ADDR_AUDIO_PATH)
            begin
                audio_hi <= rx_word[15:8];
                audio_lo <= rx_word[5:0];
            end
        end
    end

    // interval lookups in microseconds
    function [11:0] pre_us;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: pre_us = `TAC_PRE0_US;
                3'h1: pre_us = `TAC_PRE1_US;
                3'h2: pre_us = `TAC_PRE2_US;
                3'h3: pre_us = `TAC_PRE3_US;
                3'h4: pre_us = `TAC_PRE4_US;
                3'h5: pre_us = `TAC_PRE5_US;
                3'h6: pre_us = `TAC_PRE6_US;
                default: pre_us = `TAC_PRE7_US;
            endcase
        end
    endfunction

    function [11:0] sense_us;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: sense_us = `TAC_SENSE0_US;
                3'h1: sense_us = `TAC_SENSE1_US;
                3'h2: sense_us = `TAC_SENSE2_US;
                3'h3: sense_us = `TAC_SENSE3_US;
                3'h4: sense_us = `TAC_SENSE4_US;
                3'h5: sense_us = `TAC_SENSE5_US;
                3'h6: sense_us = `TAC_SENSE6_US;
                default: sense_us = `TAC_SENSE7_US;
            endcase
        end
    endfunction

    // touch sequencer: precharge interval, then sense wait
    always @*
    begin
        next_seq_state = seq_state;
        tmr_load = 1'b0;
        tmr_us = 12'h000;
        case (seq_state)
            ST_IDLE:
            begin
                if (touch_seq_start)
                begin
                    tmr_load = 1'b1;
                    tmr_us = pre_us(pre_sel);
                    next_seq_state = ST_PRE;
                end
            end
            ST_PRE:
            begin
                if (tmr_done)
                begin
                    tmr_load = 1'b1;
                    tmr_us = sense_us(sense_sel);
                    next_seq_state = ST_SENSE;
                end
            end
            ST_SENSE:
            begin
                if (tmr_done)
                    next_seq_state = ST_IDLE;
            end
            default:
                next_seq_state = ST_IDLE;
        endcase
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seq_state <= ST_IDLE;
            precharge_active <= 1'b0;
            sense_active <= 1'b0;
            touch_seq_done <= 1'b0;
        end
        else if (ce)
        begin
            if (soft_clr)
            begin
                seq_state <= ST_IDLE;
                precharge_active <= 1'b0;
                sense_active <= 1'b0;
                touch_seq_done <= 1'b0;
            end
            else
            begin
                seq_state <= next_seq_state;
                precharge_active <= (next_seq_state == ST_PRE);
                sense_active <= (next_seq_state == ST_SENSE);
                touch_seq_done <= (seq_state == ST_SENSE) & tmr_done;
            end
        end
    end

    tac_interval_timer
    #(
        .TICK_CYCLES(TICK_CYCLES)
    )
    u_timer
    (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .clr(soft_clr),
        .load(tmr_load),
        .load_us(tmr_us),
        .busy(),
        .done(tmr_done)
    );

    tac_rate_div u_play_div
    (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .clr(soft_clr),
        .base_tick(base_fs_tick),
        .sel(audio_lo[`TAC_PLAY_MSB:`TAC_PLAY_LSB]),
        .fs_tick(play_tick)
    );

    tac_rate_div u_rec_div
    (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .clr(soft_clr),
        .base_tick(base_fs_tick),
        .sel(audio_lo[`TAC_REC_MSB:`TAC_REC_LSB]),
        .fs_tick(rec_tick)
    );

    // decoded audio controls, registered so every output is a flop
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            playback_fs_tick <= 1'b0;
            record_fs_tick <= 1'b0;
            record_hpf_enable <= 1'b0;
            record_hpf_corner <= 2'b00;
            record_in_mic <= 1'b1;
            record_in_aux <= 1'b0;
            record_in_diff <= 1'b0;
            serial_word_length <= `TAC_WLEN16;
            serial_frame_format <= 4'h1;
        end
        else if (ce)
        begin
            playback_fs_tick <= play_tick;
            record_fs_tick <= rec_tick;
            // any corner code 1..3 also enables the record high-pass filter
            record_hpf_enable <= |audio_hi[7:6];
            record_hpf_corner <= audio_hi[7:6];
            record_in_mic <= (audio_hi[5:4] == 2'b00);
            record_in_aux <= (audio_hi[5:4] == 2'b01);
            record_in_diff <= audio_hi[5];
            case (audio_hi[3:2])
                2'b00: serial_word_length <= `TAC_WLEN16;
                2'b01: serial_word_length <= `TAC_WLEN20;
                2'b10: serial_word_length <= `TAC_WLEN24;
                default: serial_word_length <= `TAC_WLEN32;
            endcase
            // one-hot: bit0 i2s, bit1 dsp, bit2 right, bit3 left
            case (audio_hi[1:0])
                2'b00: serial_frame_format <= 4'h1;
                2'b01: serial_frame_format <= 4'h2;
                2'b10: serial_frame_format <= 4'h4;
                default: serial_frame_format <= 4'h8;
            endcase
        end
    end
endmodule

// File: tac_regs.vh
// register map, field positions, defaults and timing constants
`ifndef TAC_REGS_VH
`define TAC_REGS_VH

// serial command word layout
`define TAC_CMD_READ_BIT 15
`define TAC_CMD_PAGE_MSB 14
`define TAC_CMD_PAGE_LSB 11
`define TAC_CMD_ADDR_MSB 10
`define TAC_CMD_ADDR_LSB 5
`define TAC_WORD_BITS 16

// pages and register offsets
`define TAC_PAGE_TOUCH 4'h1
`define TAC_PAGE_AUDIO 4'h2
`define TAC_ADDR_SOFT_RESET 6'h04
`define TAC_ADDR_TOUCH_TIMING 6'h05
`define TAC_ADDR_AUDIO_PATH 6'h00

// reset values and the reset-all magic word
`define TAC_SOFT_RESET_DEF 16'hffff
`define TAC_TOUCH_TIMING_DEF 16'h0000
`define TAC_AUDIO_PATH_DEF 16'h0000
`define TAC_RESET_MAGIC 16'hbb00

// touch timing fields
`define TAC_PRE_MSB 5
`define TAC_PRE_LSB 3
`define TAC_SENSE_MSB 2
`define TAC_SENSE_LSB 0

// audio path fields
`define TAC_HPF_MSB 15
`define TAC_HPF_LSB 14
`define TAC_INSEL_MSB 13
`define TAC_INSEL_LSB 12
`define TAC_SERIAL_WORD_LENGTH_MSB 11
`define TAC_SERIAL_WORD_LENGTH_LSB 10
`define TAC_FMT_MSB 9
`define TAC_FMT_LSB 8
`define TAC_PLAY_MSB 5
`define TAC_PLAY_LSB 3
`define TAC_REC_MSB 2
`define TAC_REC_LSB 0

// clock rate and the microsecond tick derived from it
`define TAC_CLK_HZ 100000000
`define TAC_US_PER_SEC 1000000
`define TAC_TICK_CYCLES (`TAC_CLK_HZ / `TAC_US_PER_SEC)

// precharge intervals in microseconds
`define TAC_PRE0_US 12'd20
`define TAC_PRE1_US 12'd84
`define TAC_PRE2_US 12'd276
`define TAC_PRE3_US 12'd340
`define TAC_PRE4_US 12'd1044
`define TAC_PRE5_US 12'd1108
`define TAC_PRE6_US 12'd1300
`define TAC_PRE7_US 12'd1364

// sense intervals in microseconds
`define TAC_SENSE0_US 12'd32
`define TAC_SENSE1_US 12'd96
`define TAC_SENSE2_US 12'd544
`define TAC_SENSE3_US 12'd608
`define TAC_SENSE4_US 12'd2080
`define TAC_SENSE5_US 12'd2144
`define TAC_SENSE6_US 12'd2592
`define TAC_SENSE7_US 12'd2656

// sample-rate divisors, in half steps (divide by n/2)
`define TAC_DIV0_HALF 5'd2
`define TAC_DIV1_HALF 5'd3
`define TAC_DIV2_HALF 5'd4
`define TAC_DIV3_HALF 5'd6
`define TAC_DIV4_HALF 5'd8
`define TAC_DIV5_HALF 5'd10
`define TAC_DIV6_HALF 5'd11
`define TAC_DIV7_HALF 5'd12
`define TAC_HALF_STEP 5'd2

// serial word lengths
`define TAC_WLEN16 6'd16
`define TAC_WLEN20 6'd20
`define TAC_WLEN24 6'd24
`define TAC_WLEN32 6'd32

`endif

// File: tac_interval_timer.v
// microsecond interval timer with a load strobe and a done pulse
`timescale 1ns/100ps
`include "tac_regs.vh"
module tac_interval_timer
#(
    parameter TICK_CYCLES = `TAC_TICK_CYCLES
)
(
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire clr,
    input wire load,
    input wire [11:0] load_us,
    output reg busy,
    output reg done
);
    reg [15:0] presc;
    reg [11:0] remain;
    wire tick;

    assign tick = (presc == TICK_CYCLES[15:0] - 16'h0001);

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            presc <= 16'h0000;
            remain <= 12'h000;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else if (ce)
        begin
            done <= 1'b0;
            if (clr)
            begin
                presc <= 16'h0000;
                remain <= 12'h000;
                busy <= 1'b0;
            end
            else if (load)
            begin
                // prescaler restarts so the interval is never short
                presc <= 16'h0000;
                remain <= load_us;
                busy <= 1'b1;
            end
            else if (busy)
            begin
                presc <= tick ? 16'h0000 : presc + 16'h0001;
                if (tick)
                begin
                    remain <= remain - 12'h001;
                    if (remain == 12'h001)
                    begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end
            end
        end
    end
endmodule

// File: tac_rate_div.v
// fractional sample-rate divider working in half steps of the base rate
`timescale 1ns/100ps
`include "tac_regs.vh"
module tac_rate_div
(
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire clr,
    input wire base_tick,
    input wire [2:0] sel,
    output reg fs_tick
);
    reg [4:0] acc;
    reg [4:0] thr;
    wire [4:0] sum;

    assign sum = acc + `TAC_HALF_STEP;

    always @*
    begin
        case (sel)
            3'h0: thr = `TAC_DIV0_HALF;
            3'h1: thr = `TAC_DIV1_HALF;
            3'h2: thr = `TAC_DIV2_HALF;
            3'h3: thr = `TAC_DIV3_HALF;
            3'h4: thr = `TAC_DIV4_HALF;
            3'h5: thr = `TAC_DIV5_HALF;
            3'h6: thr = `TAC_DIV6_HALF;
            default: thr = `TAC_DIV7_HALF;
        endcase
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc <= 5'h00;
            fs_tick <= 1'b0;
        end
        else if (ce)
        begin
            fs_tick <= 1'b0;
            if (clr)
                acc <= 5'h00;
            else if (base_tick)
            begin
                // carrying the remainder spreads odd half-steps evenly
                if (sum >= thr)
                begin
                    acc <= sum - thr;
                    fs_tick <= 1'b1;
                end
                else
                    acc <= sum;
            end
        end
    end
endmodule

// File: tac_config_regs_props.sv
// concurrent checks on the configuration block's ports
`timescale 1ns/100ps
module tac_config_regs_props
(
    input wire clk,
    input wire rst_n,
    input wire touch_seq_start,
    input wire precharge_active,
    input wire sense_active,
    input wire touch_seq_done,
    input wire base_fs_tick,
    input wire playback_fs_tick,
    input wire record_fs_tick,
    input wire record_hpf_enable,
    input wire [1:0] record_hpf_corner,
    input wire record_in_mic,
    input wire record_in_aux,
    input wire record_in_diff,
    input wire [5:0] serial_word_length,
    input wire [3:0] serial_frame_format
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_hpf_enable: assert property (record_hpf_enable ==
        (record_hpf_corner != 2'h0))
        else $error("hpf enable disagrees with corner code");
    chk_input_onehot: assert property ($onehot(
        {record_in_mic, record_in_aux, record_in_diff}))
        else $error("record input select not one-hot");
    chk_word_length: assert property (serial_word_length inside
        {6'd16, 6'd20, 6'd24, 6'd32})
        else $error("illegal serial word length");
    chk_format_onehot: assert property ($onehot(serial_frame_format))
        else $error("frame format not one-hot");
    // the two touch phases never overlap
    chk_phase_apart: assert property (!(precharge_active && sense_active))
        else $error("precharge and sense active together");
    chk_sense_entry: assert property ($rose(sense_active) |->
        $fell(precharge_active))
        else $error("sense wait began without precharge ending");
    chk_precharge_start: assert property ($rose(precharge_active) |->
        $past(touch_seq_start))
        else $error("precharge began without a start request");
    chk_done_end: assert property (touch_seq_done |-> $fell(sense_active))
        else $error("done pulse not at end of sense wait");
    chk_done_pulse: assert property (touch_seq_done |=> !touch_seq_done)
        else $error("done pulse longer than one cycle");
    chk_play_cause: assert property (playback_fs_tick |->
        $past(base_fs_tick, 2))
        else $error("playback tick without base tick two cycles before");
    chk_rec_cause: assert property (record_fs_tick |->
        $past(base_fs_tick, 2))
        else $error("record tick without base tick two cycles before");
endmodule

bind tac_config_regs tac_config_regs_props chk (.clk, .rst_n,
    .touch_seq_start, .precharge_active, .sense_active, .touch_seq_done,
    .base_fs_tick, .playback_fs_tick, .record_fs_tick, .record_hpf_enable,
    .record_hpf_corner, .record_in_mic, .record_in_aux, .record_in_diff,
    .serial_word_length, .serial_frame_format);

// File: tac_host_model.sv
// host-side serial master model for the configuration port
`timescale 1ns/100ps
module tac_host_model
(
    input wire clk,
    output logic sclk,
    output logic ss_n,
    output logic mosi,
    input wire miso
);
    // each sclk phase spans several clk cycles so the sampler sees it
    localparam int PH = 4;
    initial
    begin
        sclk = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end
    // shifts n bits of w msb first; bits 17..32 of miso gathered into rd
    task automatic xfer(input logic [31:0] w, input int n,
                        output logic [15:0] rd);
        rd = 16'h0000;
        @(posedge clk);
        ss_n <= 1'b0;
        repeat (PH) @(posedge clk);
        for (int i = 0; i < n; i++)
        begin
            mosi <= w[31-i];
            repeat (PH) @(posedge clk);
            if (i >= 16)
                rd = {rd[14:0], miso};
            sclk <= 1'b1;
            repeat (PH) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (PH) @(posedge clk);
        ss_n <= 1'b1;
        // a released line must not keep showing the last bit
        mosi <= ~mosi;
        repeat (PH) @(posedge clk);
    endtask
endmodule

// File: tac_config_regs_tb_top.sv
// self-checking bench for the configuration register block
`timescale 1ns/100ps
`include "tac_regs.vh"
module tac_config_regs_tb_top;
    logic clk, rst_n, ce, touch_seq_start, base_fs_tick;
    logic sclk, ss_n, mosi, miso, miso_oe;
    logic precharge_active, sense_active, touch_seq_done;
    logic playback_fs_tick, record_fs_tick, record_hpf_enable;
    logic record_in_mic, record_in_aux, record_in_diff;
    logic [1:0] record_hpf_corner;
    logic [5:0] serial_word_length;
    logic [3:0] serial_frame_format;
    logic [15:0] rd;
    int miscompares = 0;
    int checked = 0;

    tac_config_regs #(.TICK_CYCLES(1)) DUT (.clk, .rst_n, .ce, .sclk,
        .ss_n, .mosi, .miso, .miso_oe, .touch_seq_start, .precharge_active,
        .sense_active, .touch_seq_done, .base_fs_tick, .playback_fs_tick,
        .record_fs_tick, .record_hpf_enable, .record_hpf_corner,
        .record_in_mic, .record_in_aux, .record_in_diff,
        .serial_word_length, .serial_frame_format);
    tac_host_model host (.clk, .sclk, .ss_n, .mosi, .miso);

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic write_reg(input logic [3:0] pg, input logic [5:0] a,
                             input logic [15:0] d);
        host.xfer({1'b0, pg, a, 5'h00, d}, 32, rd);
    endtask

    task automatic read_reg(input logic [3:0] pg, input logic [5:0] a);
        host.xfer({1'b1, pg, a, 5'h00, 16'h0000}, 32, rd);
    endtask

    task automatic start_seq;
        @(posedge clk);
        touch_seq_start <= 1'b1;
        @(posedge clk);
        touch_seq_start <= 1'b0;
    endtask

    task automatic check_defaults;
        read_reg(`TAC_PAGE_TOUCH, `TAC_ADDR_SOFT_RESET);
        check(rd, `TAC_SOFT_RESET_DEF);
        read_reg(`TAC_PAGE_TOUCH, `TAC_ADDR_TOUCH_TIMING);
        check(rd, `TAC_TOUCH_TIMING_DEF);
        read_reg(`TAC_PAGE_AUDIO, `TAC_ADDR_AUDIO_PATH);
        check(rd, `TAC_AUDIO_PATH_DEF);
        check({record_hpf_enable, record_in_mic, serial_frame_format,
               serial_word_length}, {2'b01, 4'h1, 6'd16});
        check({precharge_active, sense_active, miso_oe}, 3'b000);
    endtask

    task automatic t_audio;
        logic [5:0] wl[4] = '{6'd16, 6'd20, 6'd24, 6'd32};
        logic [1:0] c;
        for (int i = 0; i < 4; i++)
        begin
            c = 2'(i);
            // rate codes stay equal, so right-justified keeps a whole ratio
            write_reg(`TAC_PAGE_AUDIO, `TAC_ADDR_AUDIO_PATH,
                      {c, c, c, c, 2'b11, 6'h00});
            read_reg(`TAC_PAGE_AUDIO, `TAC_ADDR_AUDIO_PATH);
            check(rd, {c, c, c, c, 8'h00});
            check({record_hpf_enable, record_hpf_corner}, {c != 0, c});
            check({record_in_mic, record_in_aux, record_in_diff},
                  {c == 0, c == 1, c[1]});
            check(serial_word_length, wl[i]);
            check(serial_frame_format, 4'h1 << c);
        end
    endtask

    task automatic t_touch;
        int pu[8] = '{20, 84, 276, 340, 1044, 1108, 1300, 1364};
        int su[8] = '{32, 96, 544, 608, 2080, 2144, 2592, 2656};
        int np, ns, n;
        logic [2:0] p, s;
        for (int i = 0; i < 8; i++)
        begin
            p = 3'(i);
            s = 3'(7 - i);
            write_reg(`TAC_PAGE_TOUCH, `TAC_ADDR_TOUCH_TIMING,
                      {10'h000, p, s});
            read_reg(`TAC_PAGE_TOUCH, `TAC_ADDR_TOUCH_TIMING);
            check(rd, {10'h000, p, s});
            start_seq;
            np = 0;
            ns = 0;
            n = 0;
            while (touch_seq_done !== 1'b1 && n < 9000)
            begin
                @(posedge clk);
                np += precharge_active;
                ns += sense_active;
                n++;
            end
            // one extra cycle tolerated at each phase handoff
            check(np == pu[p] || np == pu[p] + 1, 1);
            check(ns == su[s] || ns == su[s] + 1, 1);
        end
    endtask

    task automatic t_rates;
        int hv[8] = '{2, 3, 4, 6, 8, 10, 11, 12};
        int np, nr;
        for (int i = 0; i < 8; i++)
        begin
            write_reg(`TAC_PAGE_TOUCH, `TAC_ADDR_SOFT_RESET,
                      `TAC_RESET_MAGIC);
            write_reg(`TAC_PAGE_AUDIO, `TAC_ADDR_AUDIO_PATH,
                      {10'h000, 3'(i), 3'(7 - i)});
            np = 0;
            nr = 0;
            // 660 base ticks make every divisor give a whole count
            for (int k = 0; k < 1324; k++)
            begin
                @(posedge clk);
                base_fs_tick <= (k < 1320) && !k[0];
                np += playback_fs_tick;
                nr += record_fs_tick;
            end
            check(np, 1320 / hv[i]);
            check(nr, 1320 / hv[7 - i]);
        end
    endtask

    task automatic t_soft;
        write_reg(`TAC_PAGE_TOUCH, `TAC_ADDR_TOUCH_TIMING,
                  16'h003f);
        write_reg(`TAC_PAGE_AUDIO, `TAC_ADDR_AUDIO_PATH, 16'hff3f);
        // reset lands in mid-precharge and must abort it
        start_seq;
        write_reg(`TAC_PAGE_TOUCH, `TAC_ADDR_SOFT_RESET,
                  `TAC_RESET_MAGIC);
        check_defaults;
    endtask

    // timing is at its defaults here: 20 us precharge, 32 us sense
    task automatic t_freeze;
        start_seq;
        ce <= 1'b0;
        repeat (100) @(posedge clk);
        check({precharge_active, sense_active}, 2'b10);
        ce <= 1'b1;
        repeat (60) @(posedge clk);
        check({precharge_active, sense_active, touch_seq_done},
              3'b000);
    endtask

    initial
    begin
        #600000;
        miscompares++;
        test_done;
    end

    initial
    begin
        rst_n = 1'b0;
        ce = 1'b1;
        touch_seq_start = 1'b0;
        base_fs_tick = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        check_defaults;
        t_audio;
        t_touch;
        t_rates;
        t_soft;
        t_freeze;
        test_done;
    end
endmodule
